// [bis_chan.sv]
// One channel: sticky source-level status and its summary flag
`timescale 1ns/1ns
`default_nettype none
`include "bis_consts.svh"
module bis_chan #(
    parameter int W = `BIS_SRC_W
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] event_in,
    input  wire logic [W-1:0] clr,
    input  wire logic         enable,
    output logic [W-1:0]      status,
    output logic              flag
);
    logic [W-1:0] next_status;  // Next sticky status

    // Read-clear of reported bits; a fresh event wins over the clear
    always_comb begin
        next_status = (status & ~clr) | event_in;
    end

    // Status register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= `BIS_RST_SRC;
        end else begin
            status <= next_status;
        end
    end

    // Flag stays up until the causing bits are read out
    // and is held off entirely by a disabled channel
    assign flag = enable & (|status);
endmodule
`default_nettype wire

// [bis_consts.svh]
// Register offsets, field positions, reset values for the interrupt summary
`ifndef BIS_CONSTS_SVH
`define BIS_CONSTS_SVH

// Register indexes; byte address is four times the index
`define BIS_IDX_SRC0     6'h02
`define BIS_IDX_SRC1     6'h0A
`define BIS_IDX_SRC2     6'h12
`define BIS_IDX_BLK_EN   6'h20
`define BIS_IDX_SUMMARY  6'h21
`define BIS_IDX_IRQ_STAT 6'h22
`define BIS_IDX_IRQ_MASK 6'h23

// Field positions of the summary register
`define BIS_BIT_CH0      0
`define BIS_BIT_CH1      1
`define BIS_BIT_CH2      2
`define BIS_SUM_USED_MSB 2
`define BIS_NUM_CH       3
`define BIS_SRC_W        8

// Reset values
`define BIS_RST_SUMMARY  8'h00
`define BIS_RST_SRC      8'h00
`define BIS_RST_CHMASK   3'h0
`define BIS_RST_DATA     32'h0000_0000

`endif

// [bis_pkg.sv]
// Types shared by the interrupt summary block
package bis_pkg;
    typedef logic [7:0]  bis_src_t;     // One source-level status byte
    typedef logic [2:0]  bis_chmask_t;  // One bit per channel
    typedef logic [2:0][7:0] bis_srcvec_t; // Source bytes of all channels
    typedef struct packed {
        logic [31:0] data;  // Read data
        logic        err;   // Slave error
    } bis_rsp_t;
endpackage

// [bis_top.sv]
// APB-reached block-level interrupt summary for three channels
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "bis_consts.svh"
module bis_top (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    input  wire bis_pkg::bis_srcvec_t src_event,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr,
    output logic                      irq
);
    import bis_pkg::*;

    // Bus phase decode
    logic        setup;        // First cycle of a transfer
    logic        access;       // Completing edge of a transfer
    logic [5:0]  idx;          // Word index from byte address

    // Register state
    bis_chmask_t blk_en;       // Block-level channel enables
    bis_chmask_t irq_stat;     // Sticky new-flag events
    bis_chmask_t irq_mask;     // Interrupt gating, 1 passes
    bis_chmask_t flag;         // Per-channel summary flags
    bis_chmask_t last_flag;    // Flags one cycle back
    bis_srcvec_t src_status;   // Source-level status bytes
    bis_srcvec_t src_clr;      // Read-clear masks per channel
    bis_chmask_t rd_clr;       // Channel read out this edge
    logic [7:0]  summary;      // Summary register image

    // Next values
    bis_chmask_t next_blk_en;
    bis_chmask_t next_irq_stat;
    bis_chmask_t next_irq_mask;
    bis_rsp_t    next_rsp;
    logic        next_pready;
    logic        next_irq;
    logic [31:0] next_prdata;  // Read data to stand through access
    logic        next_pslverr; // Error to stand through access

    assign setup  = psel & ~penable;
    assign access = psel & penable & pready;
    assign idx    = paddr[7:2];

    // Summary image: used flags in low bits, the rest tied low
    assign summary = {5'h00, flag[`BIS_BIT_CH2],
                      flag[`BIS_BIT_CH1],
                      flag[`BIS_BIT_CH0]};

    // Per-channel read-clear: only the bytes that were reported
    always_comb begin
        rd_clr  = 3'h0;
        src_clr = '0;
        if (access && !pwrite) begin
            // Status reads by the service routine clear the cause
            if (idx == `BIS_IDX_SRC0) begin
                rd_clr[0] = 1'b1;
            end
            if (idx == `BIS_IDX_SRC1) begin
                rd_clr[1] = 1'b1;
            end
            if (idx == `BIS_IDX_SRC2) begin
                rd_clr[2] = 1'b1;
            end
        end
        for (int c = 0; c < `BIS_NUM_CH; c++) begin
            // Clear the snapshot, not live status, so late events survive
            src_clr[c] = rd_clr[c] ? prdata[7:0] : 8'h00;
        end
    end

    // Channel status and flags
    generate
        for (genvar g = 0; g < `BIS_NUM_CH; g++) begin : g_ch
            bis_chan #(.W(`BIS_SRC_W)) u_chan (
                .pclk     (pclk),
                .presetn  (presetn),
                .event_in (src_event[g]),
                .clr      (src_clr[g]),
                .enable   (blk_en[g]),
                .status   (src_status[g]),
                .flag     (flag[g])
            );
        end
    endgenerate

    // Read mux, captured at setup so data stands through access
    always_comb begin
        next_rsp    = '{data: `BIS_RST_DATA, err: 1'b0};
        next_pready = setup;
        case (idx)
            `BIS_IDX_SRC0:     next_rsp.data[7:0] = src_status[0];
            `BIS_IDX_SRC1:     next_rsp.data[7:0] = src_status[1];
            `BIS_IDX_SRC2:     next_rsp.data[7:0] = src_status[2];
            `BIS_IDX_BLK_EN:   next_rsp.data[2:0] = blk_en;
            `BIS_IDX_SUMMARY:  next_rsp.data[7:0] = summary;
            `BIS_IDX_IRQ_STAT: next_rsp.data[2:0] = irq_stat;
            `BIS_IDX_IRQ_MASK: next_rsp.data[2:0] = irq_mask;
            default:           next_rsp.err       = 1'b1;  // Unmapped
        endcase
        // Load only at setup; held otherwise so a slow master still sees it
        next_prdata  = prdata;
        next_pslverr = pslverr;
        if (setup) begin
            next_prdata  = pwrite ? `BIS_RST_DATA : next_rsp.data;
            next_pslverr = next_rsp.err;
        end
    end

    // Bus response registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= `BIS_RST_DATA;
            pslverr <= 1'b0;
            pready  <= 1'b0;
        end else begin
            pready  <= next_pready;
            prdata  <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // Writable state; summary and status offsets take no write
    always_comb begin
        next_blk_en   = blk_en;
        next_irq_mask = irq_mask;
        next_irq_stat = irq_stat;
        if (access && pwrite) begin
            case (idx)
                `BIS_IDX_BLK_EN:   next_blk_en   = pwdata[2:0];
                `BIS_IDX_IRQ_MASK: next_irq_mask = pwdata[2:0];
                `BIS_IDX_IRQ_STAT: next_irq_stat = irq_stat & ~pwdata[2:0];
                default:           next_blk_en   = blk_en;
            endcase
        end
        // New flag sets its event bit; set wins over a same-edge clear
        next_irq_stat = next_irq_stat | (flag & ~last_flag);
        next_irq      = |(next_irq_stat & next_irq_mask);
    end

    // Control and interrupt registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blk_en   <= `BIS_RST_CHMASK;
            irq_mask <= `BIS_RST_CHMASK;
            irq_stat <= `BIS_RST_CHMASK;
            last_flag <= `BIS_RST_CHMASK;
            irq      <= 1'b0;
        end else begin
            blk_en   <= next_blk_en;
            irq_mask <= next_irq_mask;
            irq_stat <= next_irq_stat;
            last_flag <= flag;
            irq      <= next_irq;
        end
    end

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic rd_sum;   // Setup of a summary read
    assign rd_sum = setup && !pwrite && (idx == `BIS_IDX_SUMMARY);

    property p_sum_ch2;
        rd_sum |=> prdata[2] == $past(blk_en[2] && (|src_status[2]));
    endproperty
    a_sum_ch2: assert property (p_sum_ch2)
        else $error("summary bit 2 wrong");

    property p_sum_ch1;
        rd_sum |=> prdata[1] == $past(blk_en[1] && (|src_status[1]));
    endproperty
    a_sum_ch1: assert property (p_sum_ch1)
        else $error("summary bit 1 wrong");

    property p_sum_ch0;
        rd_sum |=> prdata[0] == $past(blk_en[0] && (|src_status[0]));
    endproperty
    a_sum_ch0: assert property (p_sum_ch0)
        else $error("summary bit 0 wrong");

    property p_hold;
        (flag[0] && !rd_clr[0] && blk_en[0]) ##1 blk_en[0] |-> flag[0];
    endproperty
    a_hold: assert property (p_hold)
        else $error("flag dropped without status read");

    property p_upper_zero;
        rd_sum ##1 penable |-> prdata[31:3] == 29'h0 && !pslverr;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("unused summary bits not zero");

    property p_disabled;
        (flag & ~blk_en) == 3'h0;
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("disabled channel raised flag");

    property p_wr_ignored;
        (access && pwrite && idx == `BIS_IDX_SUMMARY && src_event == '0)
            |=> $stable(flag) && $stable(blk_en);
    endproperty
    a_wr_ignored: assert property (p_wr_ignored)
        else $error("summary write changed state");

    property p_irq;
        // A host mask write on that edge may lawfully veto it
        $rose(flag[0]) && irq_mask[0] && !(access && pwrite)
            |=> irq && irq_stat[0];
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt not raised for new flag");
endmodule
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the block interrupt summary over APB
`timescale 1ns/1ns
`default_nettype none
`include "bis_consts.svh"
module tb_top;
    import bis_pkg::*;
    // Byte addresses: four times the register index
    localparam logic [7:0] A_EN  = {`BIS_IDX_BLK_EN, 2'b00};
    localparam logic [7:0] A_SUM = {`BIS_IDX_SUMMARY, 2'b00};
    localparam logic [7:0] A_IST = {`BIS_IDX_IRQ_STAT, 2'b00};
    localparam logic [7:0] A_IMK = {`BIS_IDX_IRQ_MASK, 2'b00};
    localparam logic [7:0] SRC_A [3] = '{{`BIS_IDX_SRC0, 2'b00},
        {`BIS_IDX_SRC1, 2'b00}, {`BIS_IDX_SRC2, 2'b00}};
    logic        pclk;       // Bus clock
    logic        presetn;    // Async reset, active low
    logic        psel;       // APB select
    logic        penable;    // APB access phase
    logic        pwrite;     // APB direction
    logic [7:0]  paddr;      // APB byte address
    logic [31:0] pwdata;     // APB write data
    bis_srcvec_t src_event;  // Source events, all channels
    logic [31:0] prdata;     // APB read data
    logic        pready;     // APB ready
    logic        pslverr;    // APB error
    logic        irq;        // Level interrupt
    int          err_total;  // Mismatches
    int          checks;     // Comparisons made

    bis_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .src_event(src_event), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq));

    // 250 MHz clock
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // Verdict and end of run
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Compare seen against expected; an unknown matches only an unknown
    task automatic chk(input string nm, input logic [32:0] seen,
                       input logic [32:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    // One APB transfer; response is {pslverr, prdata}
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [32:0] rsp);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // Ready counts only as seen at a rising edge of the access phase
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            err_total++;
            $display("APB wait timed out");
            stop_test();
        end
        // Response taken at the very edge that completes the transfer
        rsp = {pslverr, prdata};
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [32:0] r;
        apb(1'b1, a, d, r);
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a,
                         input logic [32:0] exp);
        logic [32:0] r;
        apb(1'b0, a, 32'h0000_0000, r);
        chk(nm, r, exp);
    endtask

    // One-cycle event pulse on one channel
    task automatic evt(input int c, input logic [7:0] b);
        @(posedge pclk);
        src_event[c] <= b;
        @(posedge pclk);
        src_event    <= '0;
    endtask

    // Reset values and an unmapped address
    task automatic t_reset();
        rdchk("summary", A_SUM, 33'h0_0000_0000);
        rdchk("blk_en", A_EN, 33'h0_0000_0000);
        rdchk("unmapped", 8'hFC, 33'h1_0000_0000);
        chk("irq", {32'h0000_0000, irq}, 33'h0_0000_0000);
        $display("test reset done");
    endtask

    // Disabled channel never flags, yet its source still records
    task automatic t_disabled();
        evt(0, 8'h01);
        rdchk("summary", A_SUM, 33'h0_0000_0000);
        rdchk("src0", SRC_A[0], 33'h0_0000_0001);
        $display("test disabled done");
    endtask

    // Each channel alone, then all together with a partial service
    task automatic t_flags();
        logic [31:0] m;
        wr(A_EN, 32'h0000_0007);
        wr(A_IMK, 32'h0000_0007);
        for (int c = 0; c < 3; c++) begin
            m = 32'h0000_0001 << c;
            evt(c, 8'h81);
            rdchk("summary", A_SUM, {1'b0, m});
            chk("irq", {32'h0000_0000, irq}, 33'h0_0000_0001);
            wr(A_SUM, 32'hFFFF_FFFF);
            rdchk("summary", A_SUM, {1'b0, m});
            rdchk("source", SRC_A[c], 33'h0_0000_0081);
            rdchk("summary", A_SUM, 33'h0_0000_0000);
            rdchk("irq_stat", A_IST, {1'b0, m});
            wr(A_IST, m);
            rdchk("irq_stat", A_IST, 33'h0_0000_0000);
            chk("irq", {32'h0000_0000, irq}, 33'h0_0000_0000);
        end
        for (int c = 0; c < 3; c++) begin
            evt(c, 8'h10);
        end
        rdchk("summary", A_SUM, 33'h0_0000_0007);
        rdchk("source", SRC_A[1], 33'h0_0000_0010);
        rdchk("summary", A_SUM, 33'h0_0000_0005);
        $display("test flags done");
    endtask

    // Mask holds the pin low; unmask raises it; clearing drops it
    task automatic t_mask();
        wr(A_IMK, 32'h0000_0000);
        rdchk("irq_stat", A_IST, 33'h0_0000_0007);
        chk("irq", {32'h0000_0000, irq}, 33'h0_0000_0000);
        wr(A_IMK, 32'h0000_0004);
        rdchk("irq_mask", A_IMK, 33'h0_0000_0004);
        chk("irq", {32'h0000_0000, irq}, 33'h0_0000_0001);
        wr(A_IST, 32'h0000_0007);
        rdchk("irq_stat", A_IST, 33'h0_0000_0000);
        chk("irq", {32'h0000_0000, irq}, 33'h0_0000_0000);
        rdchk("source", SRC_A[2], 33'h0_0000_0010);
        rdchk("summary", A_SUM, 33'h0_0000_0001);
        $display("test mask done");
    endtask

    // Main sequence
    initial begin
        presetn   = 1'b0;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 8'h00;
        pwdata    = 32'h0000_0000;
        src_event = '0;
        err_total = 0;
        checks    = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_disabled();
        t_flags();
        t_mask();
        stop_test();
    end
endmodule
`default_nettype wire
